/* dv/udc_bank_monitor.sv */
`timescale 1ns/10ps
module udc_bank_monitor #(
  parameter int unsigned NUM_COUNTERS = 16
) (
  input wire logic                    clock,          // clock
  input wire logic                    reset_n,        // reset
  input wire logic                    scan_tick,      // scan mark
  input wire logic [NUM_COUNTERS-1:0] clear_coil,     // clears
  input wire logic [5:0]              address,        // address
  input wire logic [15:0]             write_data,     // write data
  input wire logic                    write_strobe,   // write
  input wire logic                    read_strobe,    // read
  input wire logic [15:0]             read_data,      // read data
  input wire logic [NUM_COUNTERS-1:0] counter_contact // contacts
);
  // one clock domain, everything quiet while reset is low
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_contact_on_scan: assert property (!scan_tick |=> $stable(counter_contact))
    else $error("contact moved between scans");
  a_read_idle_zero: assert property (!read_strobe |=> read_data == '0)
    else $error("read data not zero when idle");
  a_unmapped_zero: assert property (read_strobe && address > 6'h23 |=> read_data == '0)
    else $error("unmapped read not zero");
  a_setpoint_clamp: assert property (write_strobe && address < 6'h10 && write_data > udc_pkg::VALUE_MAX
    ##1 read_strobe && address == $past(address) |=> read_data == udc_pkg::VALUE_MAX)
    else $error("setpoint not clamped");
  a_retain_masked: assert property (write_strobe && address == udc_pkg::ADDR_RETAIN
    ##1 read_strobe && address == udc_pkg::ADDR_RETAIN |=> read_data == ($past(write_data, 2) & 16'hF0F0))
    else $error("retain mask wrong");
  a_clear_zeroes: assert property (scan_tick && clear_coil[0] ##1 read_strobe && address == 6'h10
    |=> read_data == '0)
    else $error("cleared value not zero");
  a_value_holds: assert property (read_strobe && address == 6'h10 && !scan_tick
    ##1 read_strobe && address == 6'h10 && !scan_tick |=> read_data == $past(read_data))
    else $error("value moved without scan");
  a_contact_reg: assert property (read_strobe && address == 6'h23 && !scan_tick
    |=> read_data == counter_contact)
    else $error("contact register differs from pins");
  c_clear_scan: cover property (scan_tick && clear_coil[0]);
  c_contact_rise: cover property ($rose(counter_contact[0]));
  c_retain_write: cover property (write_strobe && address == udc_pkg::ADDR_RETAIN);
endmodule

bind udc_bank udc_bank_monitor #(.NUM_COUNTERS(NUM_COUNTERS)) u_mon (.clock(clock), .reset_n(reset_n),
  .scan_tick(scan_tick), .clear_coil(clear_coil), .address(address), .write_data(write_data),
  .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data), .counter_contact(counter_contact));

/* dv/udc_bank_tb.sv */
`timescale 1ns/10ps
module udc_bank_tb;
  logic        clock = 1'b0, reset_n = 1'b0, scan_tick, write_strobe = 1'b0, read_strobe = 1'b0;
  logic [15:0] pulse_coil, direction_coil, clear_coil, read_data, counter_contact, got;
  logic [15:0] want_p = 16'h0000, want_d = 16'h0000, want_c = 16'h0000, write_data = 16'h0000;
  logic [5:0]  address = 6'h00;
  logic [3:0]  fast_inputs = 4'h0;
  int          fail_count = 0, tests_run = 0;
  // rows: address, value written, value read back
  // the retain row sets no permitted bit: the store is empty before the first run
  logic [37:0] rows [6] = '{{6'h00, 16'h0003, 16'h0003}, {6'h01, 16'h7D01, 16'h7D00}, {6'h21, 16'h0F0F, 16'h0000},
                           {6'h10, 16'h0005, 16'h0000}, {6'h30, 16'h0001, 16'h0000}, {6'h20, 16'h0001, 16'h0001}};

  // clock, far side and design
  always #2.5 clock = ~clock;
  udc_ladder ladder (.clock(clock), .reset_n(reset_n), .want_p(want_p), .want_d(want_d), .want_c(want_c),
    .scan_tick(scan_tick), .pulse_coil(pulse_coil), .direction_coil(direction_coil), .clear_coil(clear_coil));
  udc_bank dut (.clock(clock), .reset_n(reset_n), .scan_tick(scan_tick), .pulse_coil(pulse_coil),
    .direction_coil(direction_coil), .clear_coil(clear_coil), .fast_inputs(fast_inputs), .address(address),
    .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .counter_contact(counter_contact));

  task automatic check(input logic [15:0] exp, input logic [15:0] act);
    tests_run++;
    if (act !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h want %h", $time, act, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clock);
    address <= a;
    write_strobe <= 1'b0;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 got = read_data;
  endtask
  // a write left standing by wr is taken at the first edge, then dropped
  task automatic scans(input int n);
    @(posedge clock);
    write_strobe <= 1'b0;
    repeat (4 * n - 1) @(posedge clock);
  endtask
  task automatic pulse(input logic [15:0] m, input int n);
    repeat (n) begin
      want_p <= m;
      scans(2);
      want_p <= 16'h0000;
      scans(2);
    end
  endtask
  task automatic wait_scan();
    int w;
    for (w = 0; w < 8 && scan_tick !== 1'b1; w++) begin
      @(posedge clock);
      #1;
    end
    if (w == 8) fail_count++;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    wrap_up();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    foreach (rows[k]) begin
      wr(rows[k][37:32], rows[k][31:16]);
      rd(rows[k][37:32]);
      check(rows[k][15:0], got);
    end
    pulse(16'h0011, 2);
    rd(6'h10);
    check(16'h0002, got);
    check(16'h0000, counter_contact & 16'h0001);
    want_p <= 16'h0001;
    scans(6);
    pulse(16'h0000, 1);
    rd(6'h10);
    check(16'h0003, got);
    check(16'h0001, counter_contact & 16'h0001);
    want_d <= 16'h0001;
    pulse(16'h0001, 1);
    rd(6'h10);
    check(16'h0002, got);
    check(16'h0000, counter_contact & 16'h0001);
    want_c <= 16'h0001;
    want_p <= 16'h0001;
    scans(2);
    wait_scan();
    rd(6'h10);
    check(16'h0000, got);
    want_c <= 16'h0000;
    pulse(16'h0000, 1);
    pulse(16'h0001, 1);
    wait_scan();
    rd(6'h10);
    check(16'h0000, got);
    rd(6'h23);
    check(16'hFFFC, got);
    want_d <= 16'h0000;
    pulse(16'h0001, 1);
    repeat (3) begin
      @(posedge clock);
      address <= 6'h10;
      read_strobe <= 1'b1;
      @(posedge clock);
      @(posedge clock);
      read_strobe <= 1'b0;
    end
    wr(6'h22, 16'h0001);
    repeat (2) begin
      scans(1);
      fast_inputs <= 4'h1;
      scans(1);
      fast_inputs <= 4'h0;
    end
    scans(1);
    rd(6'h1C);
    check(16'h0002, got);
    wr(6'h20, 16'h0000);
    scans(1);
    reset_n <= 1'b0;
    scans(2);
    reset_n <= 1'b1;
    wr(6'h21, 16'hF0F0);
    wr(6'h20, 16'h0001);
    scans(1);
    rd(6'h14);
    check(16'h0002, got);
    rd(6'h10);
    check(16'h0000, got);
    wrap_up();
  end
endmodule

/* dv/udc_ladder.sv */
`timescale 1ns/10ps
module udc_ladder (
  input  wire logic        clock,          // clock
  input  wire logic        reset_n,        // reset
  input  wire logic [15:0] want_p,         // wanted count coils
  input  wire logic [15:0] want_d,         // wanted direction coils
  input  wire logic [15:0] want_c,         // wanted clear coils
  output logic             scan_tick,      // scan mark, every 4 cycles
  output logic      [15:0] pulse_coil,     // count coils
  output logic      [15:0] direction_coil, // direction coils
  output logic      [15:0] clear_coil      // clear coils
);
  logic [1:0] phase;
  // scan sequencer and coil writer; coils move mid-scan, once a scan
  always @(posedge clock) begin
    phase <= reset_n ? phase + 2'h1 : 2'h0;
    scan_tick <= reset_n && phase == 2'h3;
    if (!reset_n || phase == 2'h1) begin
      pulse_coil <= reset_n ? want_p : 16'h0000;
      direction_coil <= reset_n ? want_d : 16'h0000;
      clear_coil <= reset_n ? want_c : 16'h0000;
    end
  end
endmodule

/* rtl/udc_bank.sv */
`timescale 1ns/10ps
module udc_bank #(
  parameter int unsigned NUM_COUNTERS = udc_pkg::NUM_COUNTERS,
  parameter int unsigned NUM_FAST     = udc_pkg::NUM_FAST
) (
  input  wire logic                       clock,           // 200 MHz system clock
  input  wire logic                       reset_n,         // synchronous reset, active low
  input  wire logic                       scan_tick,       // one-cycle pulse per program scan
  input  wire logic [NUM_COUNTERS-1:0]    pulse_coil,      // count coils
  input  wire logic [NUM_COUNTERS-1:0]    direction_coil,  // direction coils, high counts down
  input  wire logic [NUM_COUNTERS-1:0]    clear_coil,      // clear coils, high forces zero
  input  wire logic [NUM_FAST-1:0]        fast_inputs,     // fast count pins, asynchronous
  input  wire logic [udc_pkg::ADDR_W-1:0] address,         // register word address
  input  wire logic [udc_pkg::DATA_W-1:0] write_data,      // register write data
  input  wire logic                       write_strobe,    // one-cycle write request
  input  wire logic                       read_strobe,     // one-cycle read request
  output logic      [udc_pkg::DATA_W-1:0] read_data,       // read data, cycle after strobe
  output logic      [NUM_COUNTERS-1:0]    counter_contact  // value at or above setpoint
);

  // configuration and state
  logic                               run;
  logic                               run_prev;
  logic                               run_start;
  logic [udc_pkg::VALUE_W-1:0]        setpoint [NUM_COUNTERS];
  logic [udc_pkg::VALUE_W-1:0]        actual   [NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0]            retain;
  logic [NUM_FAST-1:0]                alt_mode;
  logic [NUM_FAST-1:0]                fast_meta;
  logic [NUM_FAST-1:0]                fast_sync;
  logic [NUM_FAST-1:0]                fast_prev;
  logic [NUM_FAST-1:0]                fast_edge;
  logic [udc_pkg::DATA_W-1:0]         next_read_data;
  logic [udc_pkg::ADDR_W-1:0]         addr_offset;
  logic [3:0]                         addr_index;
  logic                               wr_setpoint;
  logic [udc_pkg::VALUE_W-1:0]        clamped_setpoint;

  // two-stage synchroniser on the fast pins, then an edge detector on stage two
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      fast_meta <= '0;
      fast_sync <= '0;
      fast_prev <= '0;
    end else begin
      fast_meta <= fast_inputs;
      fast_sync <= fast_meta;
      fast_prev <= fast_sync;
    end
  end

  assign fast_edge = fast_sync & ~fast_prev;

  // run flag history, a rising run marks a restart
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      run_prev <= 1'b0;
    end else begin
      run_prev <= run;
    end
  end

  assign run_start = run & ~run_prev;

  // address split for the per-counter setpoint block
  assign addr_offset      = address - udc_pkg::ADDR_SETPOINT;
  assign addr_index       = addr_offset[3:0];
  assign wr_setpoint      = write_strobe && (address[5:4] == udc_pkg::ADDR_SETPOINT[5:4]);
  assign clamped_setpoint = (write_data > udc_pkg::VALUE_MAX) ? udc_pkg::VALUE_MAX : write_data;

  // control register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      run <= 1'b0;
    end else if (write_strobe && (address == udc_pkg::ADDR_CONTROL)) begin
      run <= write_data[udc_pkg::CTRL_RUN_BIT];
    end
  end

  // retention select, only the permitted counters take a one
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      retain <= udc_pkg::RETAIN_RST;
    end else if (write_strobe && (address == udc_pkg::ADDR_RETAIN)) begin
      retain <= write_data & udc_pkg::RETAIN_ALLOWED;
    end
  end

  // alternative mode select for the last four counters
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      alt_mode <= udc_pkg::ALT_RST;
    end else if (write_strobe && (address == udc_pkg::ADDR_ALTMODE)) begin
      alt_mode <= write_data[NUM_FAST-1:0];
    end
  end

  // setpoint store, writes above the range are clamped
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      for (int k = 0; k < NUM_COUNTERS; k++) begin
        setpoint[k] <= udc_pkg::SETPOINT_RST;
      end
    end else if (wr_setpoint) begin
      setpoint[addr_index] <= clamped_setpoint;
    end
  end

  // read decode, unmapped addresses read as zero
  always_comb begin
    next_read_data = '0;
    if (address[5:4] == udc_pkg::ADDR_SETPOINT[5:4]) begin
      next_read_data = setpoint[address[3:0]];
    end else if (address[5:4] == udc_pkg::ADDR_ACTUAL[5:4]) begin
      next_read_data = actual[address[3:0]];
    end else begin
      case (address)
        udc_pkg::ADDR_CONTROL: next_read_data = {15'h0000, run};
        udc_pkg::ADDR_RETAIN:  next_read_data = retain;
        udc_pkg::ADDR_ALTMODE: next_read_data = {12'h000, alt_mode};
        udc_pkg::ADDR_CONTACT: next_read_data = counter_contact;
        default:               next_read_data = '0;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      read_data <= '0;
    end else if (read_strobe) begin
      read_data <= next_read_data;
    end else begin
      read_data <= '0;
    end
  end

  // one counter function block per channel
  for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_counter
    logic                        pulse_prev;
    logic                        dir_held;
    logic                        clear_held;
    logic                        dir_act;
    logic                        clear_act;
    logic                        alt;
    logic                        alt_edge;
    logic                        step;
    logic                        contact;
    logic [udc_pkg::VALUE_W-1:0] value;
    logic [udc_pkg::VALUE_W-1:0] next_value;
    logic [udc_pkg::VALUE_W-1:0] cmp_value;
    logic [udc_pkg::VALUE_W-1:0] store;

    // only the last four counters have a fast input and a mode bit
    if (i >= udc_pkg::FIRST_ALT) begin : g_alt
      assign alt      = alt_mode[i-udc_pkg::FIRST_ALT];
      assign alt_edge = fast_edge[i-udc_pkg::FIRST_ALT];
    end else begin : g_norm
      assign alt      = 1'b0;
      assign alt_edge = 1'b0;
    end

    // coil states captured once per scan
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        pulse_prev <= 1'b0;
        dir_held   <= 1'b0;
        clear_held <= 1'b0;
      end else if (scan_tick) begin
        pulse_prev <= pulse_coil[i];
        dir_held   <= direction_coil[i];
        clear_held <= clear_coil[i];
      end
    end

    // coil levels in force this cycle: fresh at a scan, held between scans
    assign dir_act   = scan_tick ? direction_coil[i] : dir_held;
    assign clear_act = scan_tick ? clear_coil[i] : clear_held;

    // counted edge: scanned rising coil, or fast pin edge in alternative mode
    assign step = alt ? alt_edge : (scan_tick & pulse_coil[i] & ~pulse_prev);

    // next actual value with clear priority and saturation at both ends
    always_comb begin
      next_value = value;
      if (clear_act) begin
        next_value = udc_pkg::VALUE_MIN;
      end else if (step) begin
        if (dir_act) begin
          if (value != udc_pkg::VALUE_MIN) begin
            next_value = value - 16'h0001;
          end
        end else begin
          if (value < udc_pkg::VALUE_MAX) begin
            next_value = value + 16'h0001;
          end
        end
      end
    end

    // actual value: restore at restart, update while running, hold while stopped
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        value <= udc_pkg::VALUE_MIN;
      end else if (run_start) begin
        value <= retain[i] ? store : udc_pkg::VALUE_MIN;
      end else if (run) begin
        value <= next_value;
      end
    end

    // backing store kept through reset, stands in for non-volatile memory
    always_ff @(posedge clock) begin
      if (reset_n && run && !run_start) begin
        store <= next_value;
      end
    end

    // contact compares the value this scan ends with, so it drops at once
    assign cmp_value = (run && !run_start) ? next_value : value;

    always_ff @(posedge clock) begin
      if (!reset_n) begin
        contact <= 1'b0;
      end else if (scan_tick) begin
        contact <= (cmp_value >= setpoint[i]);
      end
    end

    assign actual[i]          = value;
    assign counter_contact[i] = contact;
  end

endmodule

/* rtl/udc_pkg.sv */
// Contract
// - sixteen independent counters, each with value, setpoint, mode and contact; the code gives a mode bit to the last four only
// - contact is on while actual value is at or above the setpoint
// - value moves by one only on a rising edge of the pulse coil
// - direction coil off counts up, direction coil on counts down
// - while the clear coil is on the actual value is zero
// - setpoint is a constant from zero to thirty-two thousand
// - counting up holds at thirty-two thousand until direction reverses
// - counting down holds at zero until direction reverses
// - with no edge and no clear the value stays unchanged
// - after reversal the contact drops in the same evaluation the value drops
// - only the last four counters accept the alternative counting mode
// - in alternative mode the last four count from the fast inputs
// - retention selectable only for counters five to eight and thirteen to sixteen
// - a retentive counter keeps its value over run to stop and power loss
// - on restart in run a retentive counter resumes from its stored value
package udc_pkg;

  // bank shape
  localparam int unsigned NUM_COUNTERS = 16;
  localparam int unsigned NUM_FAST     = 4;
  localparam int unsigned FIRST_ALT    = 12;
  localparam int unsigned VALUE_W      = 16;
  localparam int unsigned ADDR_W       = 6;
  localparam int unsigned DATA_W       = 16;

  // value range
  localparam logic [15:0] VALUE_MIN    = 16'h0000;
  localparam logic [15:0] VALUE_MAX    = 16'h7D00;
  localparam logic [15:0] SETPOINT_RST = 16'h0000;

  // counters 5..8 and 13..16 may be made retentive
  localparam logic [15:0] RETAIN_ALLOWED = 16'hF0F0;
  localparam logic [15:0] RETAIN_RST     = 16'h0000;
  localparam logic [3:0]  ALT_RST        = 4'h0;

  // register map, word addresses on the plain port
  localparam logic [5:0] ADDR_SETPOINT = 6'h00;
  localparam logic [5:0] ADDR_ACTUAL   = 6'h10;
  localparam logic [5:0] ADDR_CONTROL  = 6'h20;
  localparam logic [5:0] ADDR_RETAIN   = 6'h21;
  localparam logic [5:0] ADDR_ALTMODE  = 6'h22;
  localparam logic [5:0] ADDR_CONTACT  = 6'h23;

  // field positions
  localparam int unsigned CTRL_RUN_BIT = 0;

endpackage
